// ### core/dws_defs.svh
//==========================================================================
// Summary of operation
// - Checkword write starts only after the previous sector data write completes.
// - Erase head is switched off when the data write completes, before the first checkword byte.
// - Checkword write records the 32-bit checkword, then one pad byte.
// - Checkword write clears the write-in-progress status flag.
// - Write gate to the drive drops when the checkword write finishes.
// - Delay-with-mark-start waits 41 byte times across the sync pattern.
// - Address step fetches the expected disk address from memory into the buffer.
// - The address fetch preempts and stalls loading of further steps.
// - Two polynomial loads supply upper then lower 16 bits of the polynomial.
// - Anywhere pattern search scans read bits until an all-zeros run.
// - Next anywhere search finds first one bit and presets the bit counter.
// - Once the one-bit search is decoded, step loading stops.
// - Specific pattern step checks sync byte; continue on match, else abort.
// - Compare step checks disk address field against the fetched address.
// - Compare step saves the disk address field for error reporting.
// - After the compare, the address field checkword is read.
// - Conditional branch proceeds in order only without checkword or compare error.
// - Conditional branch with bit 15 set switches the erase heads on when it proceeds in order.
// - Delay step waits 12 byte times across the second head gap.
// - Checkword write with bit 15 set also switches heads to the next track.
//==========================================================================
// Purpose: Constants of the write sector sequencer
// Assumes: Included by its bare name
// Notes:   Step word fields are fixed by the step encoder upstream
`ifndef DWS_DEFS_SVH
`define DWS_DEFS_SVH

//==========================================================================
// Step word layout
`define DWS_OP_MSB 31
`define DWS_OP_LSB 28
`define DWS_FLAG_BIT 15
`define DWS_TGT_MSB 11
`define DWS_TGT_LSB 8
`define DWS_PAT_MSB 7
`define DWS_PAT_LSB 0
`define DWS_POLY_MSB 23
`define DWS_POLY_LSB 8

//==========================================================================
// Step operation codes
`define DWS_OP_WCHK 4'h1
`define DWS_OP_DLY_MARK 4'h2
`define DWS_OP_ADDR 4'h3
`define DWS_OP_LDPOLY 4'h4
`define DWS_OP_SRCH_ZERO 4'h5
`define DWS_OP_SRCH_ONE 4'h6
`define DWS_OP_SRCH_SYNC 4'h7
`define DWS_OP_CMP 4'h8
`define DWS_OP_RCHK 4'h9
`define DWS_OP_CBR 4'hA
`define DWS_OP_DLY 4'hB

//==========================================================================
// Sizes, timing counts and reset values
`define DWS_BUF_AW 4
`define DWS_MARK_DELAY_BYTES 8'h29
`define DWS_GAP_DELAY_BYTES 8'h0C
`define DWS_CHK_BYTES 3'h4
`define DWS_ADDR_LAST_BYTE 3'h3
`define DWS_ZERO_RUN_LAST 4'h7
`define DWS_PAD_BYTE 8'h00
`define DWS_RESET_WORD 32'h0000_0000

`endif

// ### core/dws_pkg.sv
//==========================================================================
// Purpose: Types of the write sector sequencer
// Assumes: dws_defs.svh gives the field sizes
// Notes:   State of each module is one packed struct
`include "dws_defs.svh"

package dws_pkg;

   //=======================================================================
   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WCHK_WAIT,
      ST_WCHK,
      ST_DELAY,
      ST_ADDR,
      ST_ZERO,
      ST_ONE,
      ST_SYNC,
      ST_CMP,
      ST_RCHK
   } dws_state_t;

   //=======================================================================
   // Whole sequencer state
   typedef struct packed {
      dws_state_t st;
      logic [(1 << `DWS_BUF_AW)-1:0][31:0] steps;
      logic [`DWS_BUF_AW-1:0] wr_ptr;
      logic [`DWS_BUF_AW-1:0] rd_ptr;
      logic [7:0] cnt;
      logic [2:0] idx;
      logic [3:0] zrun;
      logic flag;
      logic [7:0] pat;
      logic load_stop;
      logic poly_hi;
      logic [31:0] poly;
      logic [31:0] exp_addr;
      logic [31:0] rx_addr;
      logic [31:0] saved_addr;
      logic cmp_err;
      logic mem_req;
      logic mem_sel;
      logic erase_on;
      logic write_gate;
      logic wip;
      logic [7:0] wr_byte;
      logic wr_strobe;
      logic head_switch;
      logic mark_start;
      logic abort;
   } dws_seq_t;

   //=======================================================================
   // Bit assembler state
   typedef struct packed {
      logic [7:0] sreg;
      logic [2:0] cnt;
      logic done;
   } dws_shift_t;

endpackage

// ### core/dws_bit_shift.sv
//==========================================================================
// Purpose: Assemble read bits into bytes with a presettable bit counter
// Assumes: bit_valid marks one read bit per clock at most
// Notes:   preset counts the current bit as the first of a byte
`timescale 1ns/10ps

module dws_bit_shift (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bit_valid,
   input wire logic bit_in,
   input wire logic preset,
   output logic [7:0] rx_byte,
   output logic byte_done
);

   dws_pkg::dws_shift_t s;
   dws_pkg::dws_shift_t next_s;

   //=======================================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (bit_valid) begin
         next_s.sreg = {s.sreg[6:0], bit_in};
         if (preset) begin
            next_s.cnt = 3'h1;
         end else if (s.cnt == 3'h7) begin
            next_s.cnt = 3'h0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 3'h1;
         end
      end
   end

   //=======================================================================
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rx_byte = s.sreg;
   assign byte_done = s.done;

endmodule

// ### core/dws_sequencer.sv
//==========================================================================
// Purpose: Write sector sequencer, 1:1 interlace, address field part
// Assumes: byte_tick and bit_valid are one-cycle strobes from the drive side
// Notes:   Step buffer is a small circular store indexed by branch targets
`timescale 1ns/10ps
`include "dws_defs.svh"

module dws_sequencer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic seq_start,
   input wire logic step_valid,
   input wire logic [31:0] step_word,
   output logic step_ready,
   output logic mem_req,
   output logic mem_sel,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic byte_tick,
   input wire logic bit_valid,
   input wire logic bit_in,
   input wire logic data_write_done,
   input wire logic write_gate_set,
   input wire logic write_start,
   input wire logic [31:0] chk_word,
   input wire logic addr_crc_err,
   output logic [7:0] wr_byte,
   output logic wr_byte_strobe,
   output logic write_gate,
   output logic erase_on,
   output logic write_in_progress,
   output logic head_switch,
   output logic mark_start,
   output logic seq_abort,
   output logic [31:0] poly_word,
   output logic [31:0] exp_addr,
   output logic [31:0] saved_addr,
   output logic compare_error,
   output logic busy
);

   dws_pkg::dws_seq_t s;
   dws_pkg::dws_seq_t next_s;
   logic [7:0] rx_byte;
   logic byte_done;
   logic sync_hit;
   logic buf_empty;
   logic buf_full;

   //=======================================================================
   // Field helpers
   function automatic logic [3:0] step_op(input logic [31:0] w);
      step_op = w[`DWS_OP_MSB:`DWS_OP_LSB];
   endfunction

   function automatic logic [7:0] chk_byte(input logic [31:0] w, input logic [2:0] i);
      logic [7:0] b;
      b = `DWS_PAD_BYTE;
      unique case (i)
         3'h0: b = w[31:24];
         3'h1: b = w[23:16];
         3'h2: b = w[15:8];
         3'h3: b = w[7:0];
         default: b = `DWS_PAD_BYTE;
      endcase
      return b;
   endfunction

   //=======================================================================
   // Bit assembly
   // Preset is combinational so the found one bit is itself bit 1 of the byte
   assign sync_hit = (s.st == dws_pkg::ST_ONE) && bit_valid && bit_in;

   dws_bit_shift u_shift (
      .clk(clk),
      .rst_n(rst_n),
      .bit_valid(bit_valid),
      .bit_in(bit_in),
      .preset(sync_hit),
      .rx_byte(rx_byte),
      .byte_done(byte_done)
   );

   //=======================================================================
   // Step loading
   assign buf_empty = (s.rd_ptr == s.wr_ptr);
   assign buf_full = ((s.wr_ptr + `DWS_BUF_AW'(1)) == s.rd_ptr);
   // Memory fetch owns the memory port, so loading waits for it
   assign step_ready = !buf_full && !s.load_stop && !s.mem_req;

   //=======================================================================
   // Next state
   always_comb begin
      logic [31:0] w;
      logic [31:0] addr_word;
      w = `DWS_RESET_WORD;
      addr_word = `DWS_RESET_WORD;
      next_s = s;
      next_s.wr_strobe = 1'b0;
      next_s.head_switch = 1'b0;
      next_s.mark_start = 1'b0;
      next_s.abort = 1'b0;

      if (step_valid && step_ready) begin
         next_s.steps[s.wr_ptr] = step_word;
         next_s.wr_ptr = s.wr_ptr + `DWS_BUF_AW'(1);
      end

      unique case (s.st)
         dws_pkg::ST_IDLE: begin
            if (!buf_empty) begin
               w = s.steps[s.rd_ptr];
               next_s.rd_ptr = s.rd_ptr + `DWS_BUF_AW'(1);
               next_s.flag = w[`DWS_FLAG_BIT];
               next_s.idx = 3'h0;
               unique case (step_op(w))
                  `DWS_OP_WCHK: begin
                     next_s.st = dws_pkg::ST_WCHK_WAIT;
                  end
                  `DWS_OP_DLY_MARK: begin
                     next_s.mark_start = 1'b1;
                     next_s.cnt = `DWS_MARK_DELAY_BYTES;
                     next_s.st = dws_pkg::ST_DELAY;
                  end
                  `DWS_OP_ADDR: begin
                     next_s.mem_req = 1'b1;
                     next_s.mem_sel = 1'b0;
                     next_s.st = dws_pkg::ST_ADDR;
                  end
                  `DWS_OP_LDPOLY: begin
                     if (!s.poly_hi) begin
                        next_s.poly[31:16] = w[`DWS_POLY_MSB:`DWS_POLY_LSB];
                        next_s.poly_hi = 1'b1;
                     end else begin
                        next_s.poly[15:0] = w[`DWS_POLY_MSB:`DWS_POLY_LSB];
                        next_s.poly_hi = 1'b0;
                     end
                  end
                  `DWS_OP_SRCH_ZERO: begin
                     next_s.zrun = 4'h0;
                     next_s.st = dws_pkg::ST_ZERO;
                  end
                  `DWS_OP_SRCH_ONE: begin
                     next_s.load_stop = 1'b1;
                     next_s.st = dws_pkg::ST_ONE;
                  end
                  `DWS_OP_SRCH_SYNC: begin
                     next_s.pat = w[`DWS_PAT_MSB:`DWS_PAT_LSB];
                     next_s.st = dws_pkg::ST_SYNC;
                  end
                  `DWS_OP_CMP: begin
                     next_s.rx_addr = `DWS_RESET_WORD;
                     next_s.st = dws_pkg::ST_CMP;
                  end
                  `DWS_OP_RCHK: begin
                     next_s.st = dws_pkg::ST_RCHK;
                  end
                  `DWS_OP_CBR: begin
                     if (addr_crc_err || s.cmp_err) begin
                        next_s.rd_ptr = w[`DWS_TGT_MSB:`DWS_TGT_LSB];
                     end else if (w[`DWS_FLAG_BIT]) begin
                        next_s.erase_on = 1'b1;
                     end
                  end
                  `DWS_OP_DLY: begin
                     next_s.cnt = `DWS_GAP_DELAY_BYTES;
                     next_s.st = dws_pkg::ST_DELAY;
                  end
                  default: begin
                     // Unknown step code: treat as a broken sequence
                     next_s.abort = 1'b1;
                  end
               endcase
            end
         end

         dws_pkg::ST_WCHK_WAIT: begin
            if (data_write_done) begin
               next_s.erase_on = 1'b0;
               next_s.st = dws_pkg::ST_WCHK;
            end
         end

         dws_pkg::ST_WCHK: begin
            // Gate holds a clock past the pad
            if (s.idx > `DWS_CHK_BYTES) begin
               next_s.wip = 1'b0;
               next_s.write_gate = 1'b0;
               next_s.head_switch = s.flag;
               next_s.st = dws_pkg::ST_IDLE;
            end else if (byte_tick) begin
               next_s.wr_strobe = 1'b1;
               next_s.wr_byte = chk_byte(chk_word, s.idx);
               next_s.idx = s.idx + 3'h1;
            end
         end

         dws_pkg::ST_DELAY: begin
            if (byte_tick) begin
               next_s.cnt = s.cnt - 8'h01;
               if (s.cnt == 8'h01) begin
                  next_s.st = dws_pkg::ST_IDLE;
               end
            end
         end

         dws_pkg::ST_ADDR: begin
            if (mem_ack) begin
               if (!s.mem_sel) begin
                  next_s.exp_addr[31:16] = mem_rdata;
                  next_s.mem_sel = 1'b1;
               end else begin
                  next_s.exp_addr[15:0] = mem_rdata;
                  next_s.mem_req = 1'b0;
                  next_s.st = dws_pkg::ST_IDLE;
               end
            end
         end

         dws_pkg::ST_ZERO: begin
            if (bit_valid) begin
               if (bit_in) begin
                  next_s.zrun = 4'h0;
               end else if (s.zrun == `DWS_ZERO_RUN_LAST) begin
                  next_s.st = dws_pkg::ST_IDLE;
               end else begin
                  next_s.zrun = s.zrun + 4'h1;
               end
            end
         end

         dws_pkg::ST_ONE: begin
            if (sync_hit) begin
               next_s.st = dws_pkg::ST_IDLE;
            end
         end

         dws_pkg::ST_SYNC: begin
            if (byte_done) begin
               if (rx_byte == s.pat) begin
                  next_s.st = dws_pkg::ST_IDLE;
               end else begin
                  next_s.abort = 1'b1;
               end
            end
         end

         dws_pkg::ST_CMP: begin
            if (byte_done) begin
               addr_word = {s.rx_addr[23:0], rx_byte};
               next_s.rx_addr = addr_word;
               next_s.idx = s.idx + 3'h1;
               if (s.idx == `DWS_ADDR_LAST_BYTE) begin
                  next_s.saved_addr = addr_word;
                  next_s.cmp_err = (addr_word != s.exp_addr);
                  next_s.st = dws_pkg::ST_IDLE;
               end
            end
         end

         dws_pkg::ST_RCHK: begin
            if (byte_done) begin
               next_s.idx = s.idx + 3'h1;
               if (s.idx == `DWS_CHK_BYTES - 3'h1) begin
                  next_s.st = dws_pkg::ST_IDLE;
               end
            end
         end
      endcase

      // Sets last, so a set beats a clear
      if (write_gate_set) begin
         next_s.write_gate = 1'b1;
      end
      if (write_start) begin
         next_s.wip = 1'b1;
      end

      // Abort drops every pending step so nothing runs past a bad sync
      if (next_s.abort) begin
         next_s.st = dws_pkg::ST_IDLE;
         next_s.rd_ptr = `DWS_BUF_AW'(0);
         next_s.wr_ptr = `DWS_BUF_AW'(0);
         next_s.mem_req = 1'b0;
         next_s.load_stop = 1'b0;
      end

      if (seq_start) begin
         next_s.st = dws_pkg::ST_IDLE;
         next_s.rd_ptr = `DWS_BUF_AW'(0);
         next_s.wr_ptr = `DWS_BUF_AW'(0);
         next_s.mem_req = 1'b0;
         next_s.load_stop = 1'b0;
         next_s.poly_hi = 1'b0;
         next_s.cmp_err = 1'b0;
      end
   end

   //=======================================================================
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   //=======================================================================
   // Outputs
   assign mem_req = s.mem_req;
   assign mem_sel = s.mem_sel;
   assign wr_byte = s.wr_byte;
   assign wr_byte_strobe = s.wr_strobe;
   assign write_gate = s.write_gate;
   assign erase_on = s.erase_on;
   assign write_in_progress = s.wip;
   assign head_switch = s.head_switch;
   assign mark_start = s.mark_start;
   assign seq_abort = s.abort;
   assign poly_word = s.poly;
   assign exp_addr = s.exp_addr;
   assign saved_addr = s.saved_addr;
   assign compare_error = s.cmp_err;
   assign busy = (s.st != dws_pkg::ST_IDLE) || !buf_empty;

endmodule

// ### tb/dws_sequencer_asserts.sv
//==========================================================================
// Purpose: Port checks of the write sector sequencer
// Assumes: Byte ticks arrive several clocks apart
// Notes:   Tick windows leave out the decode cycle between two steps
`timescale 1ns/10ps

module dws_sequencer_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic seq_start,
   input wire logic step_ready,
   input wire logic mem_req,
   input wire logic mem_sel,
   input wire logic mem_ack,
   input wire logic byte_tick,
   input wire logic data_write_done,
   input wire logic wr_byte_strobe,
   input wire logic write_gate,
   input wire logic erase_on,
   input wire logic write_in_progress,
   input wire logic head_switch,
   input wire logic mark_start,
   input wire logic seq_abort,
   input wire logic busy
);
   //=======================================================================
   // Helper counters
   logic [7:0] mark_cnt, gap_cnt;
   logic erase_d, gate_d, done_seen;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mark_cnt <= 8'h00;
         gap_cnt <= 8'h00;
         erase_d <= 1'h0;
         gate_d <= 1'h0;
         done_seen <= 1'h0;
      end else begin
         mark_cnt <= mark_start ? {7'h00, byte_tick} : mark_cnt + {7'h00, byte_tick};
         gap_cnt <= (erase_on && !erase_d) ? 8'h00 : gap_cnt + {7'h00, byte_tick};
         erase_d <= erase_on;
         gate_d <= write_gate;
         done_seen <= (done_seen || data_write_done) && !seq_start && !(gate_d && !write_gate);
      end
   end

   //=======================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_write_after_done: assert property (wr_byte_strobe |-> done_seen)
      else $error("byte written before the data write ended");
   a_erase_off_write: assert property (wr_byte_strobe |-> !erase_on)
      else $error("erase head on while writing checkword");
   a_byte_per_tick: assert property (wr_byte_strobe |-> $past(byte_tick))
      else $error("byte strobe without a byte tick");
   a_wchk_end_state: assert property (head_switch |-> !write_gate && !write_in_progress)
      else $error("gate or write flag still set at head switch");
   a_mark_delay: assert property ($rose(mem_req) |-> mark_cnt == 8'h29)
      else $error("mark delay length wrong");
   a_fetch_upper_first: assert property ($rose(mem_req) |-> !mem_sel)
      else $error("fetch did not start with upper half");
   a_fetch_pair: assert property (mem_req && mem_ack && !mem_sel |=> mem_req && mem_sel)
      else $error("upper half ack did not move to lower half");
   a_fetch_end: assert property (mem_req && mem_ack && mem_sel |=> !mem_req)
      else $error("fetch request stayed after lower half");
   a_fetch_stalls_load: assert property (mem_req |-> !step_ready)
      else $error("step loading during address fetch");
   a_sync_abort: assert property (seq_abort |-> !busy)
      else $error("sequence still busy after abort");
   a_gap_delay: assert property ($rose(mark_start) && erase_on |-> gap_cnt == 8'h0C)
      else $error("head gap delay length wrong");
   c_fetch: cover property ($rose(mem_req));
   c_abort: cover property (seq_abort);
   c_head_switch: cover property (head_switch);
endmodule

bind dws_sequencer dws_sequencer_chk u_chk (.clk, .rst_n, .seq_start, .step_ready, .mem_req,
   .mem_sel, .mem_ack, .byte_tick, .data_write_done, .wr_byte_strobe, .write_gate, .erase_on,
   .write_in_progress, .head_switch, .mark_start, .seq_abort, .busy);

// ### tb/dws_drive_model.sv
//==========================================================================
// Purpose: Drive side model: byte clock, read bit stream, write capture
// Assumes: One disk byte is eight clocks
// Notes:   Idle read line toggles so a stale bit never looks valid
`timescale 1ns/10ps

module dws_drive_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] wr_byte,
   input wire logic wr_byte_strobe,
   input wire logic write_gate,
   output logic byte_tick,
   output logic bit_valid,
   output logic bit_in
);
   logic q[$];
   logic [7:0] got[$];
   int ph, wt;
   int gap = 0;

   //=======================================================================
   // Queue a byte, MSB first
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         q.push_back(b[i]);
   endtask

   //=======================================================================
   // Rotation, read bits, gated write capture
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 0;
         wt <= 0;
         byte_tick <= 1'h0;
         bit_valid <= 1'h0;
         bit_in <= 1'h0;
      end else begin
         ph <= (ph + 1) % 8;
         byte_tick <= (ph == 7);
         if (q.size() > 0 && wt >= gap) begin
            bit_in <= q.pop_front();
            bit_valid <= 1'h1;
            wt <= 0;
         end else begin
            bit_in <= ~bit_in;
            bit_valid <= 1'h0;
            wt <= wt + 1;
         end
         if (wr_byte_strobe && write_gate)
            got.push_back(wr_byte);
      end
   end
endmodule

// ### tb/tb_dws_sequencer.sv
//==========================================================================
// Purpose: Self-checking bench of the write sector sequencer
// Assumes: Pointers start at zero, so branch targets are known
// Notes:   Branch-taken case runs first for that reason
`timescale 1ns/10ps
`include "dws_defs.svh"

module tb_dws_sequencer;
   logic clk = 1'h0, rst_n = 1'h0, seq_start = 1'h0, step_valid = 1'h0, mem_ack = 1'h0;
   logic data_write_done = 1'h0, write_gate_set = 1'h0, write_start = 1'h0, addr_crc_err = 1'h0;
   logic [31:0] step_word = 32'h0, chk_word = 32'h0;
   logic [15:0] mem_rdata = 16'h0;
   logic byte_tick, bit_valid, bit_in, step_ready, mem_req, mem_sel, wr_byte_strobe;
   logic write_gate, erase_on, write_in_progress, head_switch, mark_start, seq_abort;
   logic compare_error, busy;
   logic [7:0] wr_byte;
   logic [31:0] poly_word, exp_addr, saved_addr;
   logic [31:0] sq[$], rnd = 32'h000123A8, a, p;
   logic [7:0] ew[$], pat;
   int fails = 0, total_checks = 0;
   int hs_n = 0, mk_n = 0, ab_n = 0;

   dws_sequencer DUT (.clk, .rst_n, .seq_start, .step_valid, .step_word, .step_ready, .mem_req,
      .mem_sel, .mem_ack, .mem_rdata, .byte_tick, .bit_valid, .bit_in, .data_write_done,
      .write_gate_set, .write_start, .chk_word, .addr_crc_err, .wr_byte, .wr_byte_strobe,
      .write_gate, .erase_on, .write_in_progress, .head_switch, .mark_start, .seq_abort,
      .poly_word, .exp_addr, .saved_addr, .compare_error, .busy);
   dws_drive_model DM (.clk, .rst_n, .wr_byte, .wr_byte_strobe, .write_gate, .byte_tick,
      .bit_valid, .bit_in);

   always #10 clk = ~clk;

   always @(posedge clk) begin
      hs_n += (head_switch === 1'h1);
      mk_n += (mark_start === 1'h1);
      ab_n += (seq_abort === 1'h1);
   end

   //=======================================================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
   endtask
   task automatic roll(output logic [31:0] v);
      repeat (32) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      v = rnd;
   endtask
   function automatic logic [31:0] w(input logic [3:0] op, input logic [23:0] body);
      return {op, 4'h0, body};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic load();
      foreach (sq[i]) begin
         step_valid = 1'h1;
         step_word = sq[i];
         wait_for(step_ready, 1);
         cyc(1);
      end
      step_valid = 1'h0;
   endtask
   // Zeros, sync byte, address, random checkword
   task automatic feed(input logic [7:0] sp, input logic [31:0] ad);
      logic [95:0] f;
      f = {24'h000000, sp, ad, rnd};
      for (int i = 11; i >= 0; i--)
         DM.send(f[8*i +: 8]);
   endtask
   task automatic wait_for(ref logic s, input logic v);
      for (int k = 0; k < 3000 && s !== v; k++)
         cyc(1);
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      stop_test();
   end

   //=======================================================================
   // Scenarios
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'h1;
      // Compare error: branch skips the mark step, slow bits
      roll(a);
      pat = a[7:0] | 8'h80;
      roll(a);
      sq = '{w(`DWS_OP_SRCH_ZERO, 0), w(`DWS_OP_SRCH_ONE, 0), w(`DWS_OP_SRCH_SYNC, {16'h0, pat}),
         w(`DWS_OP_CMP, 0), w(`DWS_OP_RCHK, 0), w(`DWS_OP_CBR, 24'h008700),
         w(`DWS_OP_DLY_MARK, 0), w(`DWS_OP_DLY, 0)};
      addr_crc_err = 1'h1;
      DM.gap = 2;
      load();
      feed(pat, a);
      cyc(20);
      wait_for(busy, 0);
      check("busy", busy, 0);
      check("compare_error", compare_error, 1);
      check("saved_addr", saved_addr, a);
      check("erase_on", erase_on, 0);
      check("mark count", mk_n, 0);
      check("step_ready", step_ready, 0);
      pulse(seq_start);
      check("step_ready", step_ready, 1);
      // Full sector, erase on, two checkword writes
      addr_crc_err = 1'h0;
      DM.gap = 0;
      roll(a);
      roll(p);
      roll(chk_word);
      pat = p[7:0] | 8'h80;
      ew = '{chk_word[31:24], chk_word[23:16], chk_word[15:8], chk_word[7:0], 8'h00};
      sq = '{w(`DWS_OP_WCHK, 24'h008000), w(`DWS_OP_DLY_MARK, 0), w(`DWS_OP_ADDR, 0),
         w(`DWS_OP_LDPOLY, {p[31:16], 8'h00}), w(`DWS_OP_LDPOLY, {p[15:0], 8'h00}),
         w(`DWS_OP_SRCH_ZERO, 0), w(`DWS_OP_SRCH_ONE, 0), w(`DWS_OP_SRCH_SYNC, {16'h0, pat}),
         w(`DWS_OP_CMP, 0), w(`DWS_OP_RCHK, 0), w(`DWS_OP_CBR, 24'h008000),
         w(`DWS_OP_DLY, 0), w(`DWS_OP_DLY_MARK, 0), w(`DWS_OP_WCHK, 0)};
      pulse(write_start);
      pulse(write_gate_set);
      load();
      cyc(40);
      check("write count", DM.got.size(), 0);
      pulse(data_write_done);
      wait_for(write_gate, 0);
      check("write_in_progress", write_in_progress, 0);
      check("head_switch", head_switch, 1);
      wait_for(mem_req, 1);
      for (int h = 0; h < 2; h++) begin
         check("mem_sel", mem_sel, h);
         cyc(rnd[1:0] + 1);
         mem_rdata = h ? a[15:0] : a[31:16];
         pulse(mem_ack);
      end
      cyc(8);
      check("exp_addr", exp_addr, a);
      check("poly_word", poly_word, p);
      feed(pat, a);
      wait_for(erase_on, 1);
      check("compare_error", compare_error, 0);
      check("saved_addr", saved_addr, a);
      cyc(520);
      check("mark count", mk_n, 2);
      check("write count", DM.got.size(), 5);
      pulse(write_gate_set);
      pulse(data_write_done);
      wait_for(write_gate, 0);
      check("erase_on", erase_on, 0);
      check("head switches", hs_n, 1);
      foreach (ew[i]) begin
         check("byte first", DM.got[i], ew[i]);
         check("byte second", DM.got[i + 5], ew[i]);
      end
      // Bad sync byte aborts
      pulse(seq_start);
      sq = '{w(`DWS_OP_SRCH_ZERO, 0), w(`DWS_OP_SRCH_ONE, 0), w(`DWS_OP_SRCH_SYNC, {16'h0, pat}),
         w(`DWS_OP_DLY, 0)};
      load();
      feed(pat ^ 8'h01, a);
      cyc(200);
      check("abort count", ab_n, 1);
      check("busy", busy, 0);
      check("step_ready", step_ready, 1);
      stop_test();
   end
endmodule
